/* sim/host_reader.sv */
// read-side host model: takes words from the output register, can stall
module host_reader
  import fifo_port_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // control from the bench
  input wire logic stall_in,
  // read port of the device
  input wire logic rd_valid_in,
  input wire logic [fifo_port_pkg::DATA_W-1:0] rd_data_in,
  output logic rd_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] got[$];
  initial rd_ready_out = 1'b0;
  // ready moves on the falling edge only, so it is settled at every sampling edge
  always @(negedge sys_clk_in) rd_ready_out <= !stall_in;
  always @(posedge sys_clk_in)
  begin
    if (rst_b_in && rd_valid_in && rd_ready_out)
    begin
      got.push_back(rd_data_in);
    end
  end
endmodule : host_reader

/* sim/tb_top.sv */
// self-checking bench for the multi-queue port control block
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("unexpected %s expected %h seen %h", nm, e, a); end end
module tb_top
  import fifo_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, wen_b, gate_b, sel, byp, rew, mark, clr, ren_b, oe_b, scl, sdat, sgate, stall;
  logic [2:0] wq, rq;
  logic [35:0] wd, rdata, w;
  logic rvalid, rready, oe, rstall, empty_b, full_b;
  int errors, n_compared;
  localparam logic [35:0] MBOX_WORD = 36'h9_ABCD_1234;

  multi_queue_port_ctrl #(.QUEUE_DEPTH(16), .OUT_DEPTH(16)) uut (.sys_clk_in(clk),
    .rst_b_in(rst_b), .wr_en_b_in(wen_b), .input_gate_b_in(gate_b), .wr_data_in(wd),
    .write_queue_pick_in(wq), .rd_en_b_in(ren_b), .out_en_b_in(oe_b),
    .read_queue_pick_in(rq), .rd_ready_in(rready), .rd_data_out(rdata),
    .rd_valid_out(rvalid), .rd_data_oe_out(oe), .read_stall_out(rstall),
    .config_select_in(sel), .bypass_register_select_in(byp), .rewind_pulse_in(rew),
    .mark_in(mark), .global_clear_in(clr), .serial_cfg_clk_in(scl),
    .serial_cfg_data_in(sdat), .serial_cfg_gate_in(sgate),
    .empty_indicator_b_out(empty_b), .full_indicator_b_out(full_b));
  host_reader rdr (.sys_clk_in(clk), .rst_b_in(rst_b), .stall_in(stall),
    .rd_valid_in(rvalid), .rd_data_in(rdata), .rd_ready_out(rready));

  always #2 clk = ~clk;

  function automatic logic [35:0] pat(input int i);
    return {4'hC, 16'h5A5A, 16'(i)};
  endfunction : pat

  task automatic results();
    if (errors == 0 && n_compared > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic wr(input logic s, input logic b, input logic [2:0] q, input logic [35:0] d);
    sel = s;
    byp = b;
    wq = q;
    wd = d;
    wen_b = 1'b0;
    cyc(1);
    wen_b = 1'b1;
    cyc(1);
  endtask : wr

  task automatic rchk(input logic s, input logic b, input logic [2:0] q,
    input logic [35:0] e, input string nm);
    int k;
    sel = s;
    byp = b;
    rq = q;
    ren_b = 1'b0;
    cyc(1);
    ren_b = 1'b1;
    k = 0;
    while (rdr.got.size() == 0 && k < 20)
    begin
      cyc(1);
      k++;
    end
    if (rdr.got.size() == 0)
    begin
      errors++;
      results();
    end
    else
    begin
      w = rdr.got.pop_front();
      `CHK(nm, e, w)
    end
  endtask : rchk

  // serial clock pulse, each phase well beyond the synchroniser delay
  task automatic spulse();
    cyc(4);
    scl = 1'b1;
    cyc(4);
    scl = 1'b0;
    cyc(4);
  endtask : spulse

  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    wen_b = 1'b1;
    gate_b = 1'b0;
    sel = 1'b1;
    byp = 1'b0;
    rew = 1'b0;
    mark = 1'b0;
    clr = 1'b0;
    ren_b = 1'b1;
    oe_b = 1'b0;
    scl = 1'b0;
    sdat = 1'b0;
    sgate = 1'b0;
    stall = 1'b0;
    wq = 3'h0;
    rq = 3'h0;
    wd = 36'h0;
    errors = 0;
    n_compared = 0;
    cyc(6);
    `CHK("empty_b", 1'b0, empty_b)
    `CHK("full_b", 1'b1, full_b)
    `CHK("rd_data", 36'h0, rdata)
    rst_b = 1;
    cyc(1);
    sdat = 1'b1;
    spulse();
    sgate = 1'b1;
    spulse();
    sgate = 1'b0;
    rchk(1'b0, 1'b0, 3'h0, 36'h01, "cfg0");
    wr(1'b0, 1'b0, 3'h0, 36'hF_FFFF_FFA5);
    wr(1'b0, 1'b0, 3'h0, 36'hF_FFFF_FF3C);
    rchk(1'b0, 1'b0, 3'h0, 36'h3C, "cfg1");
    wr(1'b1, 1'b1, 3'h0, MBOX_WORD);
    rchk(1'b1, 1'b1, 3'h0, MBOX_WORD, "mbox");
    wr(1'b1, 1'b0, 3'h5, pat(50));
    wr(1'b1, 1'b0, 3'h6, pat(60));
    rchk(1'b1, 1'b0, 3'h6, pat(60), "q6");
    rchk(1'b1, 1'b0, 3'h5, pat(50), "q5");
    // seventeenth word must bounce off the full queue
    for (int i = 0; i < 17; i++)
    begin
      wr(1'b1, 1'b0, 3'h1, pat(i));
    end
    rq = 3'h1;
    cyc(2);
    `CHK("full_b", 1'b0, full_b)
    `CHK("empty_b", 1'b1, empty_b)
    mark = 1'b1;
    cyc(1);
    mark = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      rchk(1'b1, 1'b0, 3'h1, pat(i), "pre_rewind");
    end
    rew = 1'b1;
    cyc(1);
    rew = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      rchk(1'b1, 1'b0, 3'h1, pat(i), "rewound");
    end
    cyc(2);
    `CHK("empty_b", 1'b0, empty_b)
    ren_b = 1'b0;
    cyc(1);
    ren_b = 1'b1;
    cyc(8);
    `CHK("no_word", 0, rdr.got.size())
    // the masked word is not stored; the pointer steps onto a slot that still holds the first word of queue 1
    gate_b = 1'b1;
    wr(1'b1, 1'b0, 3'h1, pat(7));
    gate_b = 1'b0;
    cyc(2);
    `CHK("empty_b", 1'b1, empty_b)
    rchk(1'b1, 1'b0, 3'h1, pat(0), "masked");
    wr(1'b0, 1'b0, 3'h0, 36'h77);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(2);
    `CHK("empty_b", 1'b0, empty_b)
    `CHK("full_b", 1'b1, full_b)
    `CHK("rd_data", 36'h0, rdata)
    rchk(1'b0, 1'b0, 3'h0, 36'h0, "cfg_clr");
    // output buffer: stall the reader and hold the strobe until reads are refused
    wr(1'b1, 1'b1, 3'h0, MBOX_WORD);
    stall = 1'b1;
    cyc(1);
    ren_b = 1'b0;
    cyc(24);
    `CHK("stall", 1'b1, rstall)
    ren_b = 1'b1;
    stall = 1'b0;
    cyc(30);
    `CHK("buffered", 17, rdr.got.size())
    while (rdr.got.size() > 0)
    begin
      w = rdr.got.pop_front();
      `CHK("drain", MBOX_WORD, w)
    end
    oe_b = 1'b1;
    cyc(2);
    `CHK("oe", 1'b0, oe)
    oe_b = 1'b0;
    cyc(2);
    `CHK("oe", 1'b1, oe)
    results();
  end
endmodule : tb_top

/* verilog/fifo_port_pkg.sv */
// shared constants for the multi-queue fifo port control block
package fifo_port_pkg;

  // ----------------------------------------------------------------
  // bus widths and queue organisation
  // ----------------------------------------------------------------
  localparam int DATA_W = 36;
  localparam int CFG_W = 8;
  localparam int QSEL_W = 3;
  localparam int NUM_Q = 8;
  localparam int Q_DEPTH = 16;
  localparam int OUT_FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // configuration register bank
  // ----------------------------------------------------------------
  localparam int NUM_CFG = 8;
  localparam int CFG_IDX_W = 3;
  localparam logic [CFG_IDX_W-1:0] CFG_IDX_RESET = 3'h0;
  localparam logic [CFG_W-1:0] CFG_DEFAULT = 8'h00;

  // ----------------------------------------------------------------
  // values after reset and synchroniser depth
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] DATA_RESET = 36'h0;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // source of a read fetch
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_CFG = 3'b001,
    SRC_MBOX = 3'b010,
    SRC_QUEUE = 3'b100
  } fetch_src_t;

endpackage : fifo_port_pkg

/* verilog/fifo_stream_if.sv */
// valid/ready stream carrier between the port control and its output fifo
interface fifo_stream_if #(parameter int W = 36);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  logic flush;

  modport fill (
    output push_valid,
    output push_data,
    output pop_ready,
    output flush,
    input push_ready,
    input pop_valid,
    input pop_data
  );

  modport store (
    input push_valid,
    input push_data,
    input pop_ready,
    input flush,
    output push_ready,
    output pop_valid,
    output pop_data
  );
endinterface : fifo_stream_if

/* verilog/multi_queue_port_ctrl.sv */
// port control of a multi-queue fifo: queues, mailbox, config bank, rewind
//
// Behaviour
// - a write strobe stores the word into a queue when config select is high and bypass select low, into config when config select is low.
// - a read strobe fetches from a queue when config select is high and bypass select low, from config when config select is low.
// - config transfers use the low eight data bits, queue transfers all 36 bits.
// - the active-low empty indicator is low while the read queue is empty, on the clock.
// - the active-low full indicator is low while the write queue is full, on the clock.
// - a rewind pulse reloads the read pointer with the last marked location.
// - after a rewind each read returns older data and advances until it meets the writer.
// - global clear zeroes read and write pointers and the output register.
// - global clear restores config defaults and resets empty and full indicators.
// - each serial clock rise with the gate open shifts the serial bit into the config bank.
// - the serial input is looked at only while the serial gate is open.
// - a mark pulse records the current read pointer as the rewind target.
// - with config select and bypass select high, writes and reads use one mailbox register.
// - writes and reads pick their queue through separate three-bit selects.
// - the write pointer advances on every queue write to a queue that is not full, the word lands only with input gate on.
// - data outputs are enabled while the active-low output enable is low.
module multi_queue_port_ctrl
  import fifo_port_pkg::*;
#(
  parameter int QUEUE_DEPTH = fifo_port_pkg::Q_DEPTH,
  parameter int OUT_DEPTH = fifo_port_pkg::OUT_FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // write port
  input wire logic wr_en_b_in,
  input wire logic input_gate_b_in,
  input wire logic [fifo_port_pkg::DATA_W-1:0] wr_data_in,
  input wire logic [fifo_port_pkg::QSEL_W-1:0] write_queue_pick_in,
  // read port
  input wire logic rd_en_b_in,
  input wire logic out_en_b_in,
  input wire logic [fifo_port_pkg::QSEL_W-1:0] read_queue_pick_in,
  input wire logic rd_ready_in,
  output logic [fifo_port_pkg::DATA_W-1:0] rd_data_out,
  output logic rd_valid_out,
  output logic rd_data_oe_out,
  output logic read_stall_out,
  // control
  input wire logic config_select_in,
  input wire logic bypass_register_select_in,
  input wire logic rewind_pulse_in,
  input wire logic mark_in,
  input wire logic global_clear_in,
  // serial configuration pins
  input wire logic serial_cfg_clk_in,
  input wire logic serial_cfg_data_in,
  input wire logic serial_cfg_gate_in,
  // flags
  output logic empty_indicator_b_out,
  output logic full_indicator_b_out
);
  import fifo_port_pkg::*;

  localparam int AW = $clog2(QUEUE_DEPTH);

  if (NUM_Q != (1 << QSEL_W) || QUEUE_DEPTH < 2 || (QUEUE_DEPTH & (QUEUE_DEPTH - 1)) != 0)
  begin : g_param_check
    $error("queue count must fill the select and queue depth must be a power of two");
  end

  typedef logic [AW:0] qptr_t;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  qptr_t wr_ptr_ff [NUM_Q];
  qptr_t rd_ptr_ff [NUM_Q];
  qptr_t mark_ptr_ff [NUM_Q];
  logic [DATA_W-1:0] qmem_ff [NUM_Q*QUEUE_DEPTH];
  logic [CFG_W-1:0] cfg_ff [NUM_CFG];
  logic [CFG_IDX_W-1:0] cfg_wr_idx_ff;
  logic [CFG_IDX_W-1:0] cfg_rd_idx_ff;
  logic [DATA_W-1:0] mbox_ff;
  logic [DATA_W-1:0] rd_data_ff;
  logic rd_valid_ff;
  logic oe_ff;
  logic stall_ff;
  logic empty_b_ff;
  logic full_b_ff;
  logic [SYNC_STAGES-1:0] ser_clk_sync_ff;
  logic [SYNC_STAGES-1:0] ser_data_sync_ff;
  logic [SYNC_STAGES-1:0] ser_gate_sync_ff;
  logic ser_clk_prev_ff;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  qptr_t wq_occ;
  logic wq_full;
  logic rq_empty;
  logic wr_go;
  logic cfg_wr_go;
  logic mbox_wr_go;
  logic wr_fifo_go;
  logic rd_go;
  logic rd_fifo_go;
  logic ser_shift;
  fetch_src_t fetch_src;

  fifo_stream_if #(.W(DATA_W)) out_if ();

  assign wq_occ = wr_ptr_ff[write_queue_pick_in] - rd_ptr_ff[write_queue_pick_in];
  // occupancy of a full depth sets the top bit
  assign wq_full = wq_occ[AW];
  assign rq_empty = (wr_ptr_ff[read_queue_pick_in] == rd_ptr_ff[read_queue_pick_in]);
  assign wr_go = !wr_en_b_in && !global_clear_in;
  assign cfg_wr_go = wr_go && !config_select_in;
  assign mbox_wr_go = wr_go && config_select_in && bypass_register_select_in;
  assign wr_fifo_go = wr_go && config_select_in && !bypass_register_select_in && !wq_full;
  // a fetch waits for room in the output fifo, so back-pressure reaches the strobe
  assign rd_go = !rd_en_b_in && !global_clear_in && out_if.push_ready;
  assign fetch_src = !config_select_in ? SRC_CFG :
                     (bypass_register_select_in ? SRC_MBOX : SRC_QUEUE);
  // a rewind in the same cycle wins over a queue read
  assign rd_fifo_go = rd_go && (fetch_src == SRC_QUEUE) && !rq_empty
                      && !rewind_pulse_in;
  assign ser_shift = ser_clk_sync_ff[SYNC_STAGES-1] && !ser_clk_prev_ff
                     && ser_gate_sync_ff[SYNC_STAGES-1] && !global_clear_in;

  always_comb
  begin
    out_if.push_valid = 1'b0;
    out_if.push_data = DATA_RESET;
    case (fetch_src)
      SRC_CFG:
      begin
        out_if.push_valid = rd_go;
        out_if.push_data = {{(DATA_W-CFG_W){1'b0}}, cfg_ff[cfg_rd_idx_ff]};
      end
      SRC_MBOX:
      begin
        out_if.push_valid = rd_go;
        out_if.push_data = mbox_ff;
      end
      SRC_QUEUE:
      begin
        out_if.push_valid = rd_fifo_go;
        out_if.push_data = qmem_ff[{read_queue_pick_in, rd_ptr_ff[read_queue_pick_in][AW-1:0]}];
      end
      default:
      begin
        out_if.push_valid = 1'b0;
        out_if.push_data = DATA_RESET;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // queue pointers, one set per queue
  // ----------------------------------------------------------------
  for (genvar q = 0; q < NUM_Q; q++)
  begin : g_queue
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
      if (!rst_b_in)
        wr_ptr_ff[q] <= '0;
      else if (global_clear_in)
        wr_ptr_ff[q] <= '0;
      else if (wr_fifo_go && write_queue_pick_in == QSEL_W'(q))
        wr_ptr_ff[q] <= wr_ptr_ff[q] + 1'b1;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
      if (!rst_b_in)
        rd_ptr_ff[q] <= '0;
      else if (global_clear_in)
        rd_ptr_ff[q] <= '0;
      else if (rewind_pulse_in && read_queue_pick_in == QSEL_W'(q))
        rd_ptr_ff[q] <= mark_ptr_ff[q];
      else if (rd_fifo_go && read_queue_pick_in == QSEL_W'(q))
        rd_ptr_ff[q] <= rd_ptr_ff[q] + 1'b1;
    end

    // limitation: a rewind is only exact while the writer has not lapped the mark
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
      if (!rst_b_in)
        mark_ptr_ff[q] <= '0;
      else if (global_clear_in)
        mark_ptr_ff[q] <= '0;
      else if (mark_in && read_queue_pick_in == QSEL_W'(q))
        mark_ptr_ff[q] <= rd_ptr_ff[q];
    end
  end

  // word storage carries no reset; the pointers decide what is valid
  always_ff @(posedge sys_clk_in)
  begin
    if (wr_fifo_go && !input_gate_b_in)
      qmem_ff[{write_queue_pick_in, wr_ptr_ff[write_queue_pick_in][AW-1:0]}] <= wr_data_in;
  end

  // ----------------------------------------------------------------
  // mailbox and configuration bank
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      mbox_ff <= DATA_RESET;
    else if (global_clear_in)
      mbox_ff <= DATA_RESET;
    else if (mbox_wr_go)
      mbox_ff <= wr_data_in;
  end

  // serial loading takes priority over a parallel write in the same cycle
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < NUM_CFG; i++)
        cfg_ff[i] <= CFG_DEFAULT;
    end
    else if (global_clear_in)
    begin
      for (int i = 0; i < NUM_CFG; i++)
        cfg_ff[i] <= CFG_DEFAULT;
    end
    else if (ser_shift)
    begin
      cfg_ff[0] <= {cfg_ff[0][CFG_W-2:0], ser_data_sync_ff[SYNC_STAGES-1]};
      for (int i = 1; i < NUM_CFG; i++)
        cfg_ff[i] <= {cfg_ff[i][CFG_W-2:0], cfg_ff[i-1][CFG_W-1]};
    end
    else if (cfg_wr_go)
      cfg_ff[cfg_wr_idx_ff] <= wr_data_in[CFG_W-1:0];
  end

  // config words are written and read in bank order
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cfg_wr_idx_ff <= CFG_IDX_RESET;
      cfg_rd_idx_ff <= CFG_IDX_RESET;
    end
    else if (global_clear_in)
    begin
      cfg_wr_idx_ff <= CFG_IDX_RESET;
      cfg_rd_idx_ff <= CFG_IDX_RESET;
    end
    else
    begin
      if (cfg_wr_go && !ser_shift)
        cfg_wr_idx_ff <= cfg_wr_idx_ff + 1'b1;
      if (rd_go && fetch_src == SRC_CFG)
        cfg_rd_idx_ff <= cfg_rd_idx_ff + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // serial pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ser_clk_sync_ff <= '0;
      ser_data_sync_ff <= '0;
      ser_gate_sync_ff <= '0;
      ser_clk_prev_ff <= 1'b0;
    end
    else
    begin
      ser_clk_sync_ff <= {ser_clk_sync_ff[SYNC_STAGES-2:0], serial_cfg_clk_in};
      ser_data_sync_ff <= {ser_data_sync_ff[SYNC_STAGES-2:0], serial_cfg_data_in};
      ser_gate_sync_ff <= {ser_gate_sync_ff[SYNC_STAGES-2:0], serial_cfg_gate_in};
      ser_clk_prev_ff <= ser_clk_sync_ff[SYNC_STAGES-1];
    end
  end

  // ----------------------------------------------------------------
  // flags, output fifo and output register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      empty_b_ff <= 1'b0;
      full_b_ff <= 1'b1;
    end
    else if (global_clear_in)
    begin
      empty_b_ff <= 1'b0;
      full_b_ff <= 1'b1;
    end
    else
    begin
      empty_b_ff <= !rq_empty;
      full_b_ff <= !wq_full;
    end
  end

  word_fifo #(.WIDTH(DATA_W), .DEPTH(OUT_DEPTH)) u_out_fifo (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .fifo_port(out_if.store)
  );

  assign out_if.flush = global_clear_in;
  assign out_if.pop_ready = !rd_valid_ff || rd_ready_in;

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rd_data_ff <= DATA_RESET;
      rd_valid_ff <= 1'b0;
    end
    else if (global_clear_in)
    begin
      rd_data_ff <= DATA_RESET;
      rd_valid_ff <= 1'b0;
    end
    else if (out_if.pop_ready)
    begin
      rd_valid_ff <= out_if.pop_valid;
      if (out_if.pop_valid)
        rd_data_ff <= out_if.pop_data;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      oe_ff <= 1'b0;
      stall_ff <= 1'b0;
    end
    else
    begin
      oe_ff <= !out_en_b_in;
      stall_ff <= !out_if.push_ready;
    end
  end

  assign rd_data_out = rd_data_ff;
  assign rd_valid_out = rd_valid_ff;
  assign rd_data_oe_out = oe_ff;
  assign read_stall_out = stall_ff;
  assign empty_indicator_b_out = empty_b_ff;
  assign full_indicator_b_out = full_b_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_wr_advance;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (wr_fifo_go && write_queue_pick_in == 3'h1) |=> (wr_ptr_ff[1] == $past(wr_ptr_ff[1]) + 1'b1);
  endproperty
  a_wr_advance: assert property (p_wr_advance) else $error("queue write did not advance");

  property p_cfg_write;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (cfg_wr_go && !ser_shift && cfg_wr_idx_ff == 3'h0) |=> (cfg_ff[0] == $past(wr_data_in[7:0]));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config byte not stored");

  property p_rd_advance;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (rd_fifo_go && read_queue_pick_in == 3'h1) |=> (rd_ptr_ff[1] == $past(rd_ptr_ff[1]) + 1'b1);
  endproperty
  a_rd_advance: assert property (p_rd_advance) else $error("queue read did not advance");

  property p_empty_flag;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    rq_empty |=> !empty_indicator_b_out;
  endproperty
  a_empty_flag: assert property (p_empty_flag) else $error("empty indicator not low");

  property p_full_flag;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (wq_full && !global_clear_in) |=> !full_indicator_b_out;
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full indicator not low");

  property p_rewind;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (rewind_pulse_in && read_queue_pick_in == 3'h1 && !global_clear_in)
      |=> (rd_ptr_ff[1] == $past(mark_ptr_ff[1]));
  endproperty
  a_rewind: assert property (p_rewind) else $error("rewind did not reload mark");

  property p_mark;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (mark_in && read_queue_pick_in == 3'h1 && !global_clear_in)
      |=> (mark_ptr_ff[1] == $past(rd_ptr_ff[1]));
  endproperty
  a_mark: assert property (p_mark) else $error("mark did not capture pointer");

  property p_clear;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    global_clear_in |=> (wr_ptr_ff[1] == '0 && rd_ptr_ff[1] == '0 && rd_data_out == '0
                         && !rd_valid_out);
  endproperty
  a_clear: assert property (p_clear) else $error("clear left pointers or output");

  property p_clear_cfg;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    global_clear_in |=> (cfg_ff[0] == CFG_DEFAULT && !empty_indicator_b_out
                         && full_indicator_b_out);
  endproperty
  a_clear_cfg: assert property (p_clear_cfg) else $error("clear left config or flags");

  property p_full_block;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (wr_go && config_select_in && !bypass_register_select_in && wq_full
     && write_queue_pick_in == 3'h1) |=> $stable(wr_ptr_ff[1]);
  endproperty
  a_full_block: assert property (p_full_block) else $error("write to full queue moved");

  property p_serial;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    ser_shift |=> (cfg_ff[0][0] == $past(ser_data_sync_ff[SYNC_STAGES-1])
                   && cfg_ff[1][0] == $past(cfg_ff[0][7]));
  endproperty
  a_serial: assert property (p_serial) else $error("serial bit not shifted");

  property p_mailbox;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    mbox_wr_go |=> (mbox_ff == $past(wr_data_in));
  endproperty
  a_mailbox: assert property (p_mailbox) else $error("mailbox not written");

  property p_oe;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    out_en_b_in |=> !rd_data_oe_out;
  endproperty
  a_oe: assert property (p_oe) else $error("outputs enabled while disabled");

endmodule : multi_queue_port_ctrl

/* verilog/word_fifo.sv */
// synchronous word fifo with valid/ready on both sides and a flush
module word_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // stream ports
  fifo_stream_if.store fifo_port
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_depth_check
    $error("word_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wptr_ff;
  logic [AW:0] rptr_ff;
  logic full;
  logic empty;
  logic push_go;
  logic pop_go;

  // extra pointer bit tells a full ring from an empty one
  assign empty = (wptr_ff == rptr_ff);
  assign full = (wptr_ff[AW] != rptr_ff[AW]) && (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
  assign fifo_port.push_ready = !full;
  assign fifo_port.pop_valid = !empty;
  assign fifo_port.pop_data = mem_ff[rptr_ff[AW-1:0]];
  assign push_go = fifo_port.push_valid && !full && !fifo_port.flush;
  assign pop_go = fifo_port.pop_ready && !empty && !fifo_port.flush;

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end
    else if (fifo_port.flush)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end
    else
    begin
      if (push_go)
        wptr_ff <= wptr_ff + 1'b1;
      if (pop_go)
        rptr_ff <= rptr_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (push_go)
      mem_ff[wptr_ff[AW-1:0]] <= fifo_port.push_data;
  end

endmodule : word_fifo
